// ---- bench/cals_core_asserts.sv ----
// port-level assertions for the addressing and load/store core
`timescale 1ns/10ps
module cals_core_asserts (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // program memory
  input wire logic [cals_pkg::PC_W-1:0] progAddr,
  input wire logic [7:0] progData,
  // data space
  input wire logic [7:0] dataAddr,
  input wire logic [cals_pkg::DATA_W-1:0] dataWrData,
  input wire logic dataWrEn,
  input wire logic [cals_pkg::DATA_W-1:0] dataRdData,
  // core state
  input wire logic [cals_pkg::DATA_W-1:0] accumulator,
  input wire logic zeroFlag,
  input wire logic carryFlag,
  input wire logic instrDone
);
  logic [2:0] cntReg;
  logic [2:0] cycNo;
  logic [11:0] pcReg;
  logic [7:0] opReg;
  logic [7:0] b2Reg;
  logic relTake;
  logic [11:0] relExp;
  logic oldBit;
  logic [7:0] forcedVal;
  logic [11:0] btExp;
  logic workAddr;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  function automatic logic ls_op(input logic [7:0] o);
    return (o[7:3] == 5'h1C) || (o inside {8'hC0, 8'hC1, 8'hD0, 8'hD1, 8'hF0, 8'hF1, 8'hF2, 8'hF3});
  endfunction : ls_op

  //////////////////////////////////////////////////
  // cycle 0: progAddr holds the instruction's address
  assign cycNo = instrDone ? 3'h0 : cntReg;
  assign relTake = progData[6] ? (zeroFlag ^ progData[5]) : (carryFlag ^ progData[5]);
  assign relExp = !relTake ? pcReg + 12'h001 :
                  progData[4] ? pcReg - {8'h00, progData[3:0]} : pcReg + 12'h001 + {8'h00, progData[3:0]};
  assign oldBit = dataRdData[opReg[2:0]];
  assign forcedVal = opReg[3] ? dataRdData & ~(8'h01 << opReg[2:0]) : dataRdData | (8'h01 << opReg[2:0]);
  assign btExp = (oldBit == opReg[3]) ? pcReg + 12'h001 + {{4{progData[7]}}, progData} : pcReg + 12'h003;
  // working registers are never read or written through the data port, so bit checks skip them
  assign workAddr = dataAddr[7:2] == 6'h20;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cntReg <= 3'h0;
      pcReg <= 12'h000;
      opReg <= 8'h00;
      b2Reg <= 8'h00;
    end else begin
      cntReg <= cycNo + 3'h1;
      if (cycNo == 3'h0) pcReg <= progAddr;
      if (cycNo == 3'h1) opReg <= progData;
      if (cycNo == 3'h2) b2Reg <= progData;
    end
  end

  //////////////////////////////////////////////////
  AST_LS_CYCLES: assert property ((cycNo == 3'h1 && ls_op(progData)) |=>
    !instrDone ##1 !instrDone ##1 instrDone) else $error("load/store length wrong");
  AST_REL_TARGET: assert property ((cycNo == 3'h1 && !progData[7]) |=>
    instrDone && progAddr == $past(relExp)) else $error("relative branch target wrong");
  AST_EXT_TARGET: assert property ((cycNo == 3'h3 && opReg[7:5] == 3'h4) |=>
    instrDone && progAddr == {opReg[3:0], b2Reg}) else $error("extended target wrong");
  AST_FORCE_CARRY: assert property ((cycNo == 3'h3 && opReg[7:4] == 4'hA && !workAddr) |=>
    carryFlag == $past(oldBit)) else $error("carry not old bit");
  AST_FORCE_WRITE: assert property ((cycNo == 3'h3 && opReg[7:4] == 4'hA && !workAddr) |=>
    dataWrEn && dataAddr == b2Reg && dataWrData == $past(forcedVal)) else $error("bit force write wrong");
  AST_BIT_TEST: assert property ((cycNo == 3'h3 && opReg[7:4] == 4'hB && !workAddr) |=>
    !instrDone ##1 (instrDone && progAddr == $past(btExp, 2) && carryFlag == $past(oldBit, 2)))
    else $error("bit test branch wrong");
  AST_STORE_DATA: assert property ((cycNo == 3'h1 && (progData inside {8'hC1, 8'hD1} ||
    progData[7:2] == 6'h39)) |=> dataWrData == accumulator) else $error("store data not accumulator");
  AST_CONST_MEM: assert property ((cycNo == 3'h3 && opReg == 8'hF3 && b2Reg[7:2] != 6'h20) |=>
    dataWrEn && dataAddr == b2Reg && dataWrData == $past(progData) && $stable(zeroFlag))
    else $error("constant store wrong");
  AST_LS_ZERO: assert property ((instrDone && ls_op(opReg) && opReg != 8'hF3) |->
    zeroFlag == (accumulator == 8'h00)) else $error("zero flag wrong after load/store");
  AST_LS_CARRY: assert property ((cycNo == 3'h1 && ls_op(progData)) |=>
    $stable(carryFlag)[*3]) else $error("load/store touched carry");
endmodule : cals_core_asserts

bind cals_core cals_core_asserts u_asserts (
  .core_clk(core_clk), .sys_rst(sys_rst), .progAddr(progAddr), .progData(progData),
  .dataAddr(dataAddr), .dataWrData(dataWrData), .dataWrEn(dataWrEn), .dataRdData(dataRdData),
  .accumulator(accumulator), .zeroFlag(zeroFlag), .carryFlag(carryFlag), .instrDone(instrDone)
);

// ---- bench/cals_mem_model.sv ----
// program memory and data space model on the far side of the core
`timescale 1ns/10ps
module cals_mem_model (
  // clock
  input wire logic core_clk,
  // program memory
  input wire logic [cals_pkg::PC_W-1:0] progAddr,
  output logic [7:0] progData,
  // data space
  input wire logic [7:0] dataAddr,
  input wire logic [cals_pkg::DATA_W-1:0] dataWrData,
  input wire logic dataWrEn,
  output logic [cals_pkg::DATA_W-1:0] dataRdData
);
  logic [7:0] prog [4096];
  logic [7:0] data [256];

  // the bench fills program space before each test
  initial begin
    for (int k = 0; k < 256; k++) data[k] = 8'h00;
  end

  //////////////////////////////////////////////////
  // separate program space
  always @(posedge core_clk) progData <= prog[progAddr];

  assign dataRdData = data[dataAddr];

  always @(posedge core_clk) begin
    if (dataWrEn === 1'b1) data[dataAddr] <= dataWrData;
  end
endmodule : cals_mem_model

// ---- bench/tb.sv ----
// self-checking testbench for the addressing and load/store core
`timescale 1ns/10ps
module tb;
  typedef struct packed {
    logic [7:0] pv, b0, b1, b2, da, dv;
    logic [2:0] cyc;
    logic [11:0] pc;
    logic [7:0] acc;
    logic z, c;
    logic [7:0] ca, cv;
  } cals_row_t;

  // each row: constant preload, instruction at 002, data preset, then expected results
  localparam cals_row_t ROWS [17] = '{
    '{8'h00, 8'hF0, 8'h40, 8'h00, 8'h40, 8'hA5, 3'h4, 12'h004, 8'hA5, 1'b0, 1'b0, 8'h40, 8'hA5},
    '{8'h33, 8'hF0, 8'h41, 8'h00, 8'h41, 8'h00, 3'h4, 12'h004, 8'h00, 1'b1, 1'b0, 8'h41, 8'h00},
    '{8'h5A, 8'hF1, 8'h42, 8'h00, 8'h42, 8'h00, 3'h4, 12'h004, 8'h5A, 1'b0, 1'b0, 8'h42, 8'h5A},
    '{8'h11, 8'hF2, 8'h00, 8'h00, 8'h43, 8'h00, 3'h4, 12'h004, 8'h00, 1'b1, 1'b0, 8'h43, 8'h00},
    '{8'h00, 8'hF3, 8'h44, 8'h7E, 8'h44, 8'h00, 3'h4, 12'h005, 8'h00, 1'b1, 1'b0, 8'h44, 8'h7E},
    '{8'h3C, 8'hE4, 8'h00, 8'h00, 8'h80, 8'hAA, 3'h4, 12'h003, 8'h3C, 1'b0, 1'b0, 8'h80, 8'hAA},
    '{8'h11, 8'hA3, 8'h50, 8'h00, 8'h50, 8'h00, 3'h4, 12'h004, 8'h11, 1'b0, 1'b0, 8'h50, 8'h08},
    '{8'h11, 8'hAB, 8'h51, 8'h00, 8'h51, 8'hFF, 3'h4, 12'h004, 8'h11, 1'b0, 1'b1, 8'h51, 8'hF7},
    '{8'h11, 8'h85, 8'h3C, 8'h00, 8'h00, 8'h00, 3'h4, 12'h53C, 8'h11, 1'b0, 1'b0, 8'h00, 8'h00},
    '{8'h11, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 3'h2, 12'h003, 8'h11, 1'b0, 1'b0, 8'h00, 8'h00},
    '{8'h11, 8'h2F, 8'h00, 8'h00, 8'h00, 8'h00, 3'h2, 12'h012, 8'h11, 1'b0, 1'b0, 8'h00, 8'h00},
    '{8'h11, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 3'h2, 12'hFF3, 8'h11, 1'b0, 1'b0, 8'h00, 8'h00},
    '{8'h00, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 3'h2, 12'h004, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00},
    '{8'h00, 8'h71, 8'h00, 8'h00, 8'h00, 8'h00, 3'h2, 12'h003, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00},
    '{8'h11, 8'hB2, 8'h52, 8'h10, 8'h52, 8'h00, 3'h5, 12'h013, 8'h11, 1'b0, 1'b0, 8'h52, 8'h00},
    '{8'h11, 8'hBE, 8'h53, 8'h80, 8'h53, 8'h40, 3'h5, 12'hF83, 8'h11, 1'b0, 1'b1, 8'h53, 8'h40},
    '{8'h11, 8'hBA, 8'h54, 8'hF0, 8'h54, 8'hFB, 3'h5, 12'h005, 8'h11, 1'b0, 1'b0, 8'h54, 8'hFB}
  };
  localparam logic [7:0] SEQ [13] = '{8'hF2, 8'h60, 8'hE5, 8'hF2, 8'h9C, 8'hD1, 8'hF2, 8'h00, 8'hD0,
                                      8'hE1, 8'hE6, 8'hC0, 8'hE2};
  localparam logic [7:0] SEQ_ACC [10] = '{8'h60, 8'h60, 8'h9C, 8'h9C, 8'h00, 8'h9C, 8'h60, 8'h60, 8'h5D, 8'h60};

  logic core_clk;
  logic sys_rst;
  logic [11:0] progAddr;
  logic [7:0] progData;
  logic [7:0] dataAddr;
  logic [7:0] dataWrData;
  logic dataWrEn;
  logic [7:0] dataRdData;
  logic [7:0] accumulator;
  logic zeroFlag;
  logic carryFlag;
  logic instrDone;
  int n_mismatch;
  int checked;

  cals_core dut (.core_clk(core_clk), .sys_rst(sys_rst), .progAddr(progAddr), .progData(progData),
    .dataAddr(dataAddr), .dataWrData(dataWrData), .dataWrEn(dataWrEn), .dataRdData(dataRdData),
    .accumulator(accumulator), .zeroFlag(zeroFlag), .carryFlag(carryFlag), .instrDone(instrDone));
  cals_mem_model mem (.core_clk(core_clk), .progAddr(progAddr), .progData(progData), .dataAddr(dataAddr),
    .dataWrData(dataWrData), .dataWrEn(dataWrEn), .dataRdData(dataRdData));

  always #25ns core_clk = ~core_clk;

  //////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rst_pulse(input int cyc);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (cyc) @(posedge core_clk);
    sys_rst <= 1'b0;
  endtask : rst_pulse

  // a hang ends the run
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (instrDone !== 1'b1 && n < 20);
    if (instrDone !== 1'b1) begin
      n_mismatch++;
      $display("wrong value instrDone expected 1 seen %b", instrDone);
      final_report();
    end
  endtask : wait_done

  task automatic clr_prog();
    for (int k = 0; k < 4096; k++) mem.prog[k] = 8'hF4;
  endtask : clr_prog

  //////////////////////////////////////////////////
  initial begin
    int n;
    core_clk = 1'b0;
    sys_rst = 1'b1;
    n_mismatch = 0;
    checked = 0;
    rst_pulse(20);
    foreach (ROWS[i]) begin
      clr_prog();
      mem.prog[0] = 8'hF2;
      mem.prog[1] = ROWS[i].pv;
      mem.prog[2] = ROWS[i].b0;
      mem.prog[3] = ROWS[i].b1;
      mem.prog[4] = ROWS[i].b2;
      mem.data[ROWS[i].da] = ROWS[i].dv;
      rst_pulse(2);
      wait_done(n);
      wait_done(n);
      chk("cycles", 12'(ROWS[i].cyc), n[11:0]);
      chk("progAddr", ROWS[i].pc, progAddr);
      chk("accumulator", 12'(ROWS[i].acc), 12'(accumulator));
      chk("zeroFlag", 12'(ROWS[i].z), 12'(zeroFlag));
      chk("carryFlag", 12'(ROWS[i].c), 12'(carryFlag));
      repeat (2) @(posedge core_clk);
      #1;
      chk("data byte", 12'(ROWS[i].cv), 12'(mem.data[ROWS[i].ca]));
      $display("row %0d done", i);
    end
    // working registers and both pointers, back to back
    clr_prog();
    for (int k = 0; k < 13; k++) mem.prog[k] = SEQ[k];
    mem.data[8'h00] = 8'h5D;
    mem.data[8'h81] = 8'hAA;
    rst_pulse(2);
    for (int k = 0; k < 10; k++) begin
      wait_done(n);
      chk("seq cycles", 12'h004, n[11:0]);
      chk("seq accumulator", 12'(SEQ_ACC[k]), 12'(accumulator));
    end
    repeat (2) @(posedge core_clk);
    #1;
    chk("indirect store", 12'h09C, 12'(mem.data[8'h60]));
    chk("internal register", 12'h0AA, 12'(mem.data[8'h81]));
    $display("sequence test done");
    // call then return through the stack
    clr_prog();
    mem.prog[0] = 8'h93;
    mem.prog[1] = 8'h10;
    mem.prog[12'h310] = 8'hF5;
    rst_pulse(2);
    wait_done(n);
    chk("call target", 12'h310, progAddr);
    wait_done(n);
    chk("return address", 12'h002, progAddr);
    chk("return cycles", 12'h002, n[11:0]);
    $display("call test done");
    // mid-instruction reset restarts at 000
    clr_prog();
    mem.prog[0] = 8'hF0;
    mem.prog[1] = 8'h40;
    rst_pulse(2);
    repeat (2) @(posedge core_clk);
    rst_pulse(3);
    #1;
    chk("reset progAddr", 12'h000, progAddr);
    chk("reset accumulator", 12'h000, 12'(accumulator));
    chk("reset dataWrEn", 12'h000, 12'(dataWrEn));
    chk("reset instrDone", 12'h000, 12'(instrDone));
    wait_done(n);
    chk("restart cycles", 12'h004, n[11:0]);
    chk("restart load", 12'(mem.data[8'h40]), 12'(accumulator));
    $display("reset test done");
    final_report();
  end
endmodule : tb

// ---- hdl/cals_core.sv ----
// operand addressing and load/store execution core
// Notes on behaviour
// - bit force copies old bit into carry
// - separate program, data, six-cell stack spaces
// - immediate operand is byte after opcode or after address
// - direct address byte reaches all data
// - one-byte short direct picks 80h-83h register
// - extended target joins opcode nibble and byte
// - relative branch spans -15 to +16
// - relative opcode: test, direction, magnitude fields
// - bit number in opcode, address follows
// - bit test: opcode, address, signed displacement
// - indirect through pointer chosen by bit 4
// - inherent instructions are single byte only
// - loads and stores move accumulator and memory
// - four cycles, byte counts, zero/carry effects
`timescale 1ns/10ps
module cals_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // program memory
  output logic [cals_pkg::PC_W-1:0] progAddr,
  input wire logic [7:0] progData,
  // data space memory
  output logic [7:0] dataAddr,
  output logic [cals_pkg::DATA_W-1:0] dataWrData,
  output logic dataWrEn,
  input wire logic [cals_pkg::DATA_W-1:0] dataRdData,
  // core state
  output logic [cals_pkg::DATA_W-1:0] accumulator,
  output logic zeroFlag,
  output logic carryFlag,
  output logic instrDone
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  cals_pkg::cals_state_t state, next_state;
  logic [cals_pkg::PC_W-1:0] pc, next_pc;
  logic [cals_pkg::PC_W-1:0] next_progAddr;
  logic [2:0] phase, next_phase;
  logic [7:0] op, next_op;
  logic [7:0] b2, next_b2;
  logic [cals_pkg::DATA_W-1:0] next_acc;
  logic next_zero, next_carry;
  logic [cals_pkg::DATA_W-1:0] workReg [0:3];
  logic hitPending;
  logic [1:0] hitIdx;
  logic rdReq, wrReq, push, pop, done;
  logic [7:0] rdAddr, wrAddr;
  logic [cals_pkg::DATA_W-1:0] wrVal;
  logic [cals_pkg::PC_W-1:0] target, pushVal, stackTop;
  cals_pkg::cals_data_bus_t next_bus;

  ////////////////////////////////////////////////////////////////////////////////
  // decode and selection

  function automatic logic isWork(input logic [7:0] addr);
    return addr[7:2] == cals_pkg::ADDR_POINTER_ONE[7:2];
  endfunction : isWork

  function automatic logic [7:0] workAddr(input logic [1:0] idx);
    return {cals_pkg::ADDR_POINTER_ONE[7:2], idx};
  endfunction : workAddr

  function automatic logic isZero(input logic [cals_pkg::DATA_W-1:0] v);
    return v == cals_pkg::DATA_ZERO;
  endfunction : isZero

  wire [7:0] curOp = (state == cals_pkg::ST_OP) ? progData : op;
  wire cals_pkg::cals_dec_t dec = cals_pkg::cals_decode(curOp);
  wire [2:0] lastPhase = dec.cycles - 3'h1;
  wire [2:0] bitNum = curOp[cals_pkg::OP_BITNUM_MSB:0];
  wire [3:0] magnitude = curOp[cals_pkg::OP_MAG_MSB:0];
  wire [2:0] testType = curOp[7:cals_pkg::OP_TEST_LSB];
  wire [1:0] shortIdx = curOp[cals_pkg::OP_SHORT_MSB:0];
  wire [7:0] pointerVal = workReg[{1'b0, curOp[cals_pkg::OP_PTR_BIT]}];
  // internal working registers answer in place of data memory
  wire [cals_pkg::DATA_W-1:0] rdValue = hitPending ? workReg[hitIdx] : dataRdData;
  wire oldBit = rdValue[bitNum];
  wire [cals_pkg::DATA_W-1:0] bitMask = cals_pkg::DATA_W'(1) << bitNum;
  // test type field picks the condition
  wire relTaken = (testType == cals_pkg::TEST_CARRY_SET) ? carryFlag :
    (testType == cals_pkg::TEST_CARRY_CLEAR) ? !carryFlag :
    (testType == cals_pkg::TEST_ZERO_SET) ? zeroFlag :
    (testType == cals_pkg::TEST_ZERO_CLEAR) ? !zeroFlag : 1'b0;
  // forward adds magnitude plus one, backward subtracts magnitude
  wire [cals_pkg::PC_W-1:0] relTarget = curOp[cals_pkg::OP_DIR_BIT] ?
    pc - {8'h00, magnitude} :
    pc + cals_pkg::PC_STEP_ONE + {8'h00, magnitude};
  // nibble as upper part, second byte as lower
  wire [cals_pkg::PC_W-1:0] extTarget = {curOp[cals_pkg::OP_MAG_MSB:0], progData};
  wire [cals_pkg::PC_W-1:0] testTarget = pc + cals_pkg::PC_STEP_ONE + {{4{progData[7]}}, progData};
  wire testTaken = curOp[cals_pkg::OP_SENSE_BIT] ? oldBit : !oldBit;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_progAddr = progAddr;
    next_phase = phase + 3'h1;
    next_op = op;
    next_b2 = b2;
    next_acc = accumulator;
    next_zero = zeroFlag;
    next_carry = carryFlag;
    rdReq = 1'b0;
    rdAddr = dataAddr;
    wrReq = 1'b0;
    wrAddr = dataAddr;
    wrVal = dataWrData;
    push = 1'b0;
    pop = 1'b0;
    pushVal = pc + cals_pkg::PC_STEP_TWO;
    done = 1'b0;
    target = pc;
    case (state)
      cals_pkg::ST_FETCH: begin
        // prefetch the next byte so operands stream one per cycle
        next_progAddr = pc + cals_pkg::PC_STEP_ONE;
        next_state = cals_pkg::ST_OP;
      end
      cals_pkg::ST_OP: begin
        next_op = progData;
        next_progAddr = pc + cals_pkg::PC_STEP_TWO;
        next_state = cals_pkg::ST_B2;
        target = pc + cals_pkg::PC_STEP_ONE;
        case (dec.kind)
          cals_pkg::CL_RELATIVE: begin
            done = 1'b1;
            target = relTaken ? relTarget : pc + cals_pkg::PC_STEP_ONE;
          end
          cals_pkg::CL_LOAD_IND: begin
            rdReq = 1'b1;
            rdAddr = pointerVal;
            next_state = cals_pkg::ST_MEM;
          end
          cals_pkg::CL_STORE_IND, cals_pkg::CL_STORE_SHORT: begin
            // accumulator to pointed or short byte
            wrReq = 1'b1;
            wrAddr = (dec.kind == cals_pkg::CL_STORE_IND) ? pointerVal : workAddr(shortIdx);
            wrVal = accumulator;
            next_zero = isZero(accumulator);
            done = 1'b1;
          end
          cals_pkg::CL_LOAD_SHORT: begin
            next_acc = workReg[shortIdx];
            next_zero = isZero(workReg[shortIdx]);
            done = 1'b1;
          end
          cals_pkg::CL_NOP: done = 1'b1;
          cals_pkg::CL_RET: begin
            pop = 1'b1;
            target = stackTop;
            done = 1'b1;
          end
          default: next_state = cals_pkg::ST_B2;
        endcase
      end
      cals_pkg::ST_B2: begin
        next_b2 = progData;
        next_state = cals_pkg::ST_MEM;
        target = pc + cals_pkg::PC_STEP_TWO;
        case (dec.kind)
          cals_pkg::CL_LONG_JUMP, cals_pkg::CL_CALL: begin
            push = (dec.kind == cals_pkg::CL_CALL);
            target = extTarget;
            done = 1'b1;
          end
          cals_pkg::CL_BIT_DIRECT, cals_pkg::CL_LOAD_DIR, cals_pkg::CL_BIT_TEST: begin
            // second byte is the data address
            rdReq = 1'b1;
            rdAddr = progData;
            if (dec.kind == cals_pkg::CL_BIT_TEST) next_state = cals_pkg::ST_B3;
          end
          cals_pkg::CL_STORE_DIR: begin
            wrReq = 1'b1;
            wrAddr = progData;
            wrVal = accumulator;
            next_zero = isZero(accumulator);
            done = 1'b1;
          end
          cals_pkg::CL_CONST_ACC: begin
            // operand is the byte after the opcode
            next_acc = progData;
            next_zero = isZero(progData);
            done = 1'b1;
          end
          cals_pkg::CL_CONST_MEM: next_state = cals_pkg::ST_B3;
          default: done = 1'b1;
        endcase
      end
      cals_pkg::ST_B3: begin
        done = 1'b1;
        if (dec.kind == cals_pkg::CL_BIT_TEST) begin
          // untaken test falls past all three bytes
          next_carry = oldBit;
          target = testTaken ? testTarget : pc + cals_pkg::PC_STEP_THREE;
        end else begin
          // constant into any data byte, zero untouched
          wrReq = 1'b1;
          wrAddr = b2;
          wrVal = progData;
          target = pc + cals_pkg::PC_STEP_THREE;
        end
      end
      cals_pkg::ST_MEM: begin
        done = 1'b1;
        target = (dec.kind == cals_pkg::CL_LOAD_IND) ? pc + cals_pkg::PC_STEP_ONE : pc + cals_pkg::PC_STEP_TWO;
        if (dec.kind == cals_pkg::CL_BIT_DIRECT) begin
          next_carry = oldBit;
          wrReq = 1'b1;
          wrAddr = b2;
          wrVal = curOp[cals_pkg::OP_SENSE_BIT] ? (rdValue & ~bitMask) : (rdValue | bitMask);
        end else begin
          next_acc = rdValue;
          next_zero = isZero(rdValue);
        end
      end
      cals_pkg::ST_PAD: begin
        done = 1'b1;
      end
      default: next_state = cals_pkg::ST_FETCH;
    endcase
    // hold every instruction to its cycle count
    if (done) begin
      next_pc = target;
      if (phase >= lastPhase) begin
        next_state = cals_pkg::ST_FETCH;
        next_progAddr = target;
        next_phase = 3'h0;
      end else begin
        next_state = cals_pkg::ST_PAD;
      end
    end
  end

  assign next_bus.addr = wrReq ? wrAddr : (rdReq ? rdAddr : dataAddr);
  assign next_bus.wrData = wrReq ? wrVal : dataWrData;
  assign next_bus.wrEn = wrReq && !isWork(wrAddr);

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= cals_pkg::ST_FETCH;
      pc <= cals_pkg::RESET_PC;
      progAddr <= cals_pkg::RESET_PC;
      phase <= 3'h0;
      op <= 8'h00;
      b2 <= 8'h00;
      accumulator <= cals_pkg::DATA_ZERO;
      zeroFlag <= 1'b0;
      carryFlag <= 1'b0;
      dataAddr <= 8'h00;
      dataWrData <= cals_pkg::DATA_ZERO;
      dataWrEn <= 1'b0;
      hitPending <= 1'b0;
      hitIdx <= 2'h0;
      instrDone <= 1'b0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      progAddr <= next_progAddr;
      phase <= next_phase;
      op <= next_op;
      b2 <= next_b2;
      accumulator <= next_acc;
      zeroFlag <= next_zero;
      carryFlag <= next_carry;
      {dataAddr, dataWrData, dataWrEn} <= next_bus;
      hitPending <= rdReq && isWork(rdAddr);
      hitIdx <= rdAddr[1:0];
      instrDone <= done && (phase >= lastPhase);
    end
  end

  // working registers live in the core at 80h-83h
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) begin
        workReg[i] <= cals_pkg::WORK_RESET;
      end
    end else if (wrReq && isWork(wrAddr)) begin
      workReg[wrAddr[1:0]] <= wrVal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // return stack

  // six return cells of program counter width
  cals_return_stack #(
    .DEPTH(cals_pkg::STACK_DEPTH),
    .WIDTH(cals_pkg::PC_W)
  ) u_stack (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .push(push),
    .pop(pop),
    .pushData(pushVal),
    .topData(stackTop)
  );

endmodule : cals_core

// ---- hdl/cals_return_stack.sv ----
// six-cell return address stack
`timescale 1ns/10ps
module cals_return_stack #(
  parameter int DEPTH = cals_pkg::STACK_DEPTH,
  parameter int WIDTH = cals_pkg::PC_W
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // stack operations
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] pushData,
  output logic [WIDTH-1:0] topData
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

  logic [WIDTH-1:0] cells [0:DEPTH-1];
  logic [PTR_W-1:0] ptr;
  logic [PTR_W-1:0] topIdx;

  // ptr points at the next free cell; a seventh nested call overwrites the oldest
  assign topIdx = (ptr == '0) ? PTR_LAST : ptr - PTR_ONE;
  assign topData = cells[topIdx];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ptr <= '0;
    end else if (push) begin
      cells[ptr] <= pushData;
      ptr <= (ptr == PTR_LAST) ? '0 : ptr + PTR_ONE;
    end else if (pop) begin
      ptr <= topIdx;
    end
  end

endmodule : cals_return_stack

// ---- shared/cals_pkg.sv ----
// shared constants, types and decode for the core
package cals_pkg;

  localparam int PC_W = 12;
  localparam int DATA_W = 8;
  localparam int STACK_DEPTH = 6;

  localparam logic [PC_W-1:0] RESET_PC = 12'h000;
  localparam logic [PC_W-1:0] PC_STEP_ONE = 12'h001;
  localparam logic [PC_W-1:0] PC_STEP_TWO = 12'h002;
  localparam logic [PC_W-1:0] PC_STEP_THREE = 12'h003;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  // working registers in data space
  localparam logic [7:0] ADDR_POINTER_ONE = 8'h80;
  localparam logic [7:0] ADDR_POINTER_SECOND = 8'h81;
  localparam logic [7:0] ADDR_SHORT_REG_THIRD = 8'h82;
  localparam logic [7:0] ADDR_SHORT_REG_FOURTH = 8'h83;
  localparam logic [7:0] WORK_RESET = 8'h00;

  // opcode field positions
  localparam int OP_CLASS_MSB = 7;
  localparam int OP_CLASS_LSB = 4;
  localparam int OP_TEST_LSB = 5;
  localparam int OP_DIR_BIT = 4;
  localparam int OP_PTR_BIT = 4;
  localparam int OP_MAG_MSB = 3;
  localparam int OP_SENSE_BIT = 3;
  localparam int OP_BITNUM_MSB = 2;
  localparam int OP_SHORT_MSB = 1;

  // high nibble classes; opcodes below 80h are relative branches
  localparam logic [3:0] NIB_LONG_JUMP = 4'h8;
  localparam logic [3:0] NIB_CALL = 4'h9;
  localparam logic [3:0] NIB_BIT_DIRECT = 4'hA;
  localparam logic [3:0] NIB_BIT_TEST = 4'hB;
  localparam logic [3:0] NIB_IND_ONE = 4'hC;
  localparam logic [3:0] NIB_IND_TWO = 4'hD;
  localparam logic [3:0] NIB_SHORT = 4'hE;
  localparam logic [3:0] NIB_MISC = 4'hF;
  // low nibble selectors
  localparam logic [3:0] LOW_IND_LOAD = 4'h0;
  localparam logic [3:0] LOW_IND_STORE = 4'h1;
  localparam logic [3:0] LOW_DIR_LOAD = 4'h0;
  localparam logic [3:0] LOW_DIR_STORE = 4'h1;
  localparam logic [3:0] LOW_CONST_ACC = 4'h2;
  localparam logic [3:0] LOW_CONST_MEM = 4'h3;
  localparam logic [3:0] LOW_RET = 4'h5;
  localparam logic [1:0] SHORT_LOAD = 2'h0;
  localparam logic [1:0] SHORT_STORE = 2'h1;

  // relative branch test types
  localparam logic [2:0] TEST_CARRY_SET = 3'h0;
  localparam logic [2:0] TEST_CARRY_CLEAR = 3'h1;
  localparam logic [2:0] TEST_ZERO_SET = 3'h2;
  localparam logic [2:0] TEST_ZERO_CLEAR = 3'h3;

  // cycles per instruction
  localparam logic [2:0] CYC_LOAD = 3'h4;
  localparam logic [2:0] CYC_RELATIVE = 3'h2;
  localparam logic [2:0] CYC_BIT_TEST = 3'h5;
  localparam logic [2:0] CYC_BIT_DIRECT = 3'h4;
  localparam logic [2:0] CYC_EXTENDED = 3'h4;
  localparam logic [2:0] CYC_CONTROL = 3'h2;

  typedef enum logic [3:0] {
    CL_RELATIVE = 4'b0000,
    CL_LONG_JUMP = 4'b0001,
    CL_CALL = 4'b0010,
    CL_BIT_DIRECT = 4'b0011,
    CL_BIT_TEST = 4'b0100,
    CL_LOAD_IND = 4'b0101,
    CL_STORE_IND = 4'b0110,
    CL_LOAD_SHORT = 4'b0111,
    CL_STORE_SHORT = 4'b1000,
    CL_LOAD_DIR = 4'b1001,
    CL_STORE_DIR = 4'b1010,
    CL_CONST_ACC = 4'b1011,
    CL_CONST_MEM = 4'b1100,
    CL_NOP = 4'b1101,
    CL_RET = 4'b1110
  } cals_class_t;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_OP = 3'b001,
    ST_B2 = 3'b010,
    ST_B3 = 3'b011,
    ST_MEM = 3'b100,
    ST_PAD = 3'b101
  } cals_state_t;

  typedef struct packed {
    cals_class_t kind;
    logic [2:0] cycles;
  } cals_dec_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wrEn;
  } cals_data_bus_t;

  function automatic cals_dec_t cals_decode(input logic [7:0] op);
    cals_dec_t d;
    logic [3:0] nib;
    logic [3:0] low;
    nib = op[OP_CLASS_MSB:OP_CLASS_LSB];
    low = op[OP_MAG_MSB:0];
    d = '{CL_NOP, CYC_CONTROL};
    if (!op[OP_CLASS_MSB]) begin
      d = '{CL_RELATIVE, CYC_RELATIVE};
    end else begin
      case (nib)
        NIB_LONG_JUMP: d = '{CL_LONG_JUMP, CYC_EXTENDED};
        NIB_CALL: d = '{CL_CALL, CYC_EXTENDED};
        NIB_BIT_DIRECT: d = '{CL_BIT_DIRECT, CYC_BIT_DIRECT};
        NIB_BIT_TEST: d = '{CL_BIT_TEST, CYC_BIT_TEST};
        NIB_IND_ONE, NIB_IND_TWO: begin
          if (low == LOW_IND_LOAD) d = '{CL_LOAD_IND, CYC_LOAD};
          else if (low == LOW_IND_STORE) d = '{CL_STORE_IND, CYC_LOAD};
        end
        NIB_SHORT: begin
          if (low[OP_MAG_MSB:OP_BITNUM_MSB] == SHORT_LOAD) d = '{CL_LOAD_SHORT, CYC_LOAD};
          else if (low[OP_MAG_MSB:OP_BITNUM_MSB] == SHORT_STORE) d = '{CL_STORE_SHORT, CYC_LOAD};
        end
        NIB_MISC: begin
          case (low)
            LOW_DIR_LOAD: d = '{CL_LOAD_DIR, CYC_LOAD};
            LOW_DIR_STORE: d = '{CL_STORE_DIR, CYC_LOAD};
            LOW_CONST_ACC: d = '{CL_CONST_ACC, CYC_LOAD};
            LOW_CONST_MEM: d = '{CL_CONST_MEM, CYC_LOAD};
            LOW_RET: d = '{CL_RET, CYC_CONTROL};
            default: d = '{CL_NOP, CYC_CONTROL};
          endcase
        end
        default: d = '{CL_NOP, CYC_CONTROL};
      endcase
    end
    return d;
  endfunction : cals_decode

endpackage : cals_pkg
